// ### common/lpc_regs.vh
// Register offsets, field positions and reset values for
// the light profiler control block. Included by the design, the checker and the bench.
`ifndef LPC_REGS_VH
`define LPC_REGS_VH
// Register addresses on the model-specific register port.
`define LPC_ADDR_FEATURE_CONFIG 32'hC0000105
`define LPC_ADDR_CONTROL_BLOCK  32'hC0000106
// Reset values.
`define LPC_RESET_CONFIG        64'h0000000000000000
`define LPC_RESET_ADDRESS       64'h0000000000000000
// Feature configuration field positions.
`define LPC_CFG_EVENT_LO        1
`define LPC_CFG_EVENT_HI        6
`define LPC_CFG_CONTINUOUS_MODE_ENABLE_BIT        29
`define LPC_CFG_TSC_BIT         30
`define LPC_CFG_INT_BIT         31
`define LPC_CFG_CORE_LO         32
`define LPC_CFG_CORE_HI         39
`define LPC_CFG_VEC_LO          40
`define LPC_CFG_VEC_HI          47
// Writable mask of the configuration register (bits 31:1 and 47:32).
`define LPC_CFG_WRITABLE        64'h0000FFFFFFFFFFFE
// Identification and enable bit positions.
`define LPC_CAP_BIT             15
`define LPC_XFE_BIT             62
// Number of counted events (ids 1 to 6).
`define LPC_NUM_EVENTS          6
`endif

// ### rtl/lpc_profiler_ctrl.v
// Control and configuration registers of the light profiler, with the
// load-control-block sequence. Assumes a core pipeline that supplies the
// register port, the instruction request and memory answers as one-cycle
// strobes synchronous to clk_in; all values arrive already checked by it.
//
// How it works
// - Registers reachable only with capability bit 15.
// - Usable only with enable bit 62; starts disabled.
// - Config write of unsupported bit: protection fault.
// - Config bits 39:32 give the core identifier.
// - Config bits 47:40 give interrupt vector.
// - Config register resets to zero.
// - Config bits 1..6 allow each event.
// - Continuous mode only when bit 29 set.
// - Bit 30 with timestamp present stores timestamp.
// - Threshold interrupt only when bit 31 set.
// - Address read returns value, no side effect.
// - Non-zero address write: protection fault.
// - Zero address write disables, discards state.
// - Instructions fault invalid opcode when unavailable.
// - Load faults first if unavailable or unprotected.
// - Load flushes old block; page fault keeps it.
// - Zero load address: disabled, done after flush.
// - Limit or size failure: fault, left disabled.
// - Linear addresses add segment base, kept.
// - Flags pruned to available, written back.
// - Intervals except the first raised to minimum; counters loaded.
// - Counter zero or negative: record next event.
//
// Behaviour notes for the next engineer.
// The register port answers every access to the two mapped addresses
// with one pulse one cycle later, reg_ack_out or gp_fault_out, except that
// a check failure or page-fault answer in the same cycle sets gp_fault_out to check_fail_in.
// Accesses to any other address get no answer at all; the core is
// expected to route those elsewhere.
// A rejected configuration write leaves the stored value untouched, so
// software that ignores the fault keeps the previous permissions.
// The load sequence is a small state machine: idle, flush and check.
// Only one load is in flight at a time; a second load request that
// arrives while the machine is busy is dropped without an answer,
// except for the availability and protected-mode tests, which must fault at once.
// The flush and check steps are carried out by the core, which pulses
// the matching done, page-fault or failure input back to this block.
// A page fault during the check leaves the profiler disabled and raises
// no protection fault here, because the core reports the page fault.
// Interval and counter words are taken only on the check-done pulse;
// they are ignored at every other time.
// Clearing the enable bit in the extended feature register forces the
// profiler off on the next edge but keeps the stored block address, so
// a later state restore can resume from it.
// Counters are held here only to decide whether the next event must be
// recorded; counting down and reloading belong to the event logic.
// Threshold interrupts need both the configuration permission and the
// interrupt flag that survived pruning at load time.
// All state freezes while ce_in is low, including the one-cycle strobes,
// so a strobe that is high when the enable drops stays high until the
// enable returns; the core must not sample strobes while it holds ce_in
// low.
`include "lpc_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module lpc_profiler_ctrl #(
    parameter [31:0] MIN_INTERVAL = 32'h0000000F // Implementation minimum.
) (
    // Clock, reset and clock enable.
    input  wire        clk_in,
    input  wire        rst_in,
    input  wire        ce_in,
    // Processor state.
    input  wire        cap_present_in,      // Identification bit 15.
    input  wire        ext_feature_en_in,   // Enable register bit 62.
    input  wire        protected_mode_in,
    input  wire        timestamp_avail_in,
    input  wire [31:0] supported_feat_in,   // Supported feature bits.
    input  wire [63:0] data_seg_base_in,
    // Register port.
    input  wire        reg_rd_in,
    input  wire        reg_wr_in,
    input  wire [31:0] reg_addr_in,
    input  wire [63:0] reg_wdata_in,
    output reg  [63:0] reg_rdata_out,
    output reg         reg_ack_out,
    output reg         gp_fault_out,
    // Instruction request.
    input  wire        instr_in,            // Any profiler instruction.
    input  wire        load_in,             // Load-control-block request.
    input  wire [63:0] load_addr_in,
    output reg         ud_fault_out,
    output reg         load_done_out,
    // Memory step answers from the core.
    output reg         flush_req_out,
    input  wire        flush_done_in,
    input  wire        flush_pf_in,
    output reg         check_req_out,
    input  wire        check_done_in,
    input  wire        check_fail_in,       // Limit or buffer size error.
    input  wire        check_pf_in,
    input  wire [63:0] ring_addr_in,        // Ring buffer effective address.
    input  wire [31:0] block_flags_in,
    input  wire [191:0] intervals_in,       // Six 32-bit intervals.
    input  wire [191:0] counters_in,        // Six 32-bit counters.
    output reg  [31:0] pruned_flags_out,
    output reg         flags_wb_out,
    // Profiler state to the event logic.
    input  wire [5:0]  event_hit_in,        // Event occurrences.
    output reg         enabled_out,
    output reg  [63:0] ring_linear_out,
    output reg  [5:0]  record_req_out,
    output reg  [7:0]  core_id_out,
    output reg  [7:0]  vector_out,
    output reg         continuous_out,
    output reg         store_tsc_out,
    output reg         int_allow_out,
    output reg  [191:0] interval_out
);
    // Load sequence states. Idle waits for a request, flush waits for the
    // core to save the old block, check waits for validation answers.
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_FLUSH = 2'h1;
    localparam [1:0] ST_CHECK = 2'h2;

    reg [63:0]  config_q;         // Feature configuration register.
    reg [63:0]  address_q;        // Linear control block address.
    reg [1:0]   state;            // Load sequence state.
    reg [63:0]  pend_addr;        // Requested load address.
    reg [191:0] count_q;          // Internal event counters.

    // Bits that software may set in the configuration register.
    function [63:0] allowed_mask;
        input [31:0] sup;
        begin
            allowed_mask = {16'h0000, 16'hFFFF, sup[31:1], 1'b0};
        end
    endfunction

    // Profiler instructions need the capability and enable bit 62; registers need only the capability.
    wire avail = cap_present_in & ext_feature_en_in;
    wire [63:0] cfg_next = reg_wdata_in;
    wire cfg_hit = reg_addr_in == `LPC_ADDR_FEATURE_CONFIG;
    wire adr_hit = reg_addr_in == `LPC_ADDR_CONTROL_BLOCK;
    // Flags that survive pruning: supported and allowed by config.
    wire [31:0] avail_flags = supported_feat_in & config_q[31:0];
    // The interrupt flag survives only if software asked for it as well.
    wire [31:0] next_flags  = {block_flags_in[31] & avail_flags[31],
                               24'h000000,
                               block_flags_in[6:1] & avail_flags[6:1],
                               1'b0};

    integer i;

    // Main sequential process; all state frozen while ce_in is low.
    always @(posedge clk_in) begin
        if (rst_in) begin
            config_q       <= `LPC_RESET_CONFIG;
            address_q      <= `LPC_RESET_ADDRESS;
            state          <= ST_IDLE;
            pend_addr      <= 64'h0000000000000000;
            count_q        <= 192'h0;
            reg_rdata_out  <= 64'h0000000000000000;
            reg_ack_out    <= 1'b0;
            gp_fault_out   <= 1'b0;
            ud_fault_out   <= 1'b0;
            load_done_out  <= 1'b0;
            flush_req_out  <= 1'b0;
            check_req_out  <= 1'b0;
            pruned_flags_out <= 32'h00000000;
            flags_wb_out   <= 1'b0;
            enabled_out    <= 1'b0;
            ring_linear_out <= 64'h0000000000000000;
            record_req_out <= 6'h00;
            core_id_out    <= 8'h00;
            vector_out     <= 8'h00;
            continuous_out <= 1'b0;
            store_tsc_out  <= 1'b0;
            int_allow_out  <= 1'b0;
            interval_out   <= 192'h0;
        end else if (ce_in) begin
            // Strobes default low.
            reg_ack_out   <= 1'b0;
            gp_fault_out  <= 1'b0;
            ud_fault_out  <= 1'b0;
            load_done_out <= 1'b0;
            flush_req_out <= 1'b0;
            check_req_out <= 1'b0;
            flags_wb_out  <= 1'b0;
            // Register accesses; unreachable without capability.
            if ((reg_rd_in | reg_wr_in) && (cfg_hit | adr_hit)) begin
                if (!cap_present_in) begin
                    gp_fault_out <= 1'b1;
                end else if (reg_rd_in) begin
                    reg_ack_out   <= 1'b1;
                    reg_rdata_out <= cfg_hit ? config_q
                                             : address_q;
                end else if (cfg_hit) begin
                    if (|(cfg_next & ~allowed_mask(supported_feat_in)))
                        gp_fault_out <= 1'b1;
                    else begin
                        config_q    <= cfg_next;
                        reg_ack_out <= 1'b1;
                    end
                end else if (|reg_wdata_in) begin
                    gp_fault_out <= 1'b1;
                end else begin
                    // Zero write stops at once, nothing saved.
                    address_q   <= 64'h0000000000000000;
                    enabled_out <= 1'b0;
                    count_q     <= 192'h0;
                    state       <= ST_IDLE;
                    reg_ack_out <= 1'b1;
                end
            end
            // Instruction request handling.
            // Unavailable profiler faults every instruction first.
            if (instr_in && !avail) begin
                ud_fault_out <= 1'b1;
            end else if (load_in && !protected_mode_in) begin
                // Faults before any other action, even while busy.
                ud_fault_out <= 1'b1;
            end else if (load_in && state == ST_IDLE) begin
                // Remember the address for the later steps.
                pend_addr <= load_addr_in;
                if (enabled_out) begin
                    // Save the old block before touching the new one.
                    flush_req_out <= 1'b1;
                    state <= ST_FLUSH;
                end else if (load_addr_in == 64'h0) begin
                    // Nothing to validate; already disabled.
                    load_done_out <= 1'b1;
                end else begin
                    // Ask the core to validate the new block.
                    check_req_out <= 1'b1;
                    state <= ST_CHECK;
                end
            end
            // Load sequence steps driven by the core's answers.
            case (state)
                ST_IDLE: begin
                end
                ST_FLUSH: begin
                    if (flush_pf_in) begin
                        // Old block stays active and enabled.
                        state <= ST_IDLE;
                    end else if (flush_done_in) begin
                        if (pend_addr == 64'h0) begin
                            enabled_out   <= 1'b0;
                            address_q     <= 64'h0;
                            load_done_out <= 1'b1;
                            state <= ST_IDLE;
                        end else begin
                            enabled_out   <= 1'b0;
                            check_req_out <= 1'b1;
                            state <= ST_CHECK;
                        end
                    end
                end
                ST_CHECK: begin
                    if (check_fail_in | check_pf_in) begin
                        gp_fault_out <= check_fail_in;
                        enabled_out  <= 1'b0;
                        address_q    <= 64'h0;
                        state <= ST_IDLE;
                    end else if (check_done_in) begin
                        address_q <= pend_addr + data_seg_base_in;
                        ring_linear_out <= ring_addr_in
                                         + data_seg_base_in;
                        pruned_flags_out <= next_flags;
                        flags_wb_out  <= 1'b1;
                        for (i = 0; i < `LPC_NUM_EVENTS; i = i + 1) begin
                            interval_out[i*32 +: 32] <=
                                (i != 0 && intervals_in[i*32 +: 32]
                                 < MIN_INTERVAL) ? MIN_INTERVAL
                                : intervals_in[i*32 +: 32];
                        end
                        count_q <= counters_in;
                        enabled_out   <= 1'b1;
                        load_done_out <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
            // Without enable bit 62 the profiler is off.
            if (!ext_feature_en_in) begin
                enabled_out <= 1'b0;
            end
            // Record request on event with counter zero or negative.
            for (i = 0; i < `LPC_NUM_EVENTS; i = i + 1) begin
                record_req_out[i] <= enabled_out & event_hit_in[i]
                    & config_q[`LPC_CFG_EVENT_LO + i]
                    & pruned_flags_out[i + 1]
                    & (count_q[i*32 +: 32] == 32'h0
                       || count_q[i*32 + 31]);
            end
            core_id_out    <= config_q[`LPC_CFG_CORE_HI:`LPC_CFG_CORE_LO];
            vector_out     <= config_q[`LPC_CFG_VEC_HI:`LPC_CFG_VEC_LO];
            continuous_out <= config_q[`LPC_CFG_CONTINUOUS_MODE_ENABLE_BIT];
            store_tsc_out  <= config_q[`LPC_CFG_TSC_BIT]
                            & timestamp_avail_in;
            int_allow_out  <= config_q[`LPC_CFG_INT_BIT]
                            & pruned_flags_out[31];
        end
    end
    // core_id_out feeds every record's core identifier field.
endmodule
`default_nettype wire

// ### testbench/lpc_ctrl_sva.sv
// Checker of the profiler control port timing and register gating.
// Assumes one-cycle request strobes and answers one cycle after them.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_regs.vh"
module lpc_ctrl_sva (
    // Clock, reset and processor state.
    input wire logic        clk_in, rst_in, ce_in, cap_present_in,
    input wire logic        ext_feature_en_in, protected_mode_in,
    // Register port.
    input wire logic        reg_rd_in, reg_wr_in, reg_ack_out, gp_fault_out,
    input wire logic [31:0] reg_addr_in,
    input wire logic [63:0] reg_wdata_in,
    // Instruction and profiler state.
    input wire logic        instr_in, load_in, ud_fault_out, load_done_out,
    input wire logic        check_req_out, check_fail_in, enabled_out,
    input wire logic        continuous_out, int_allow_out,
    input wire logic [63:0] load_addr_in,
    input wire logic [31:0] pruned_flags_out,
    input wire logic [7:0]  core_id_out, vector_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // Decoded requests as the block takes them.
    wire cfg_a = reg_addr_in == `LPC_ADDR_FEATURE_CONFIG;
    wire cba_a = reg_addr_in == `LPC_ADDR_CONTROL_BLOCK;
    wire acc = ce_in && (reg_rd_in || reg_wr_in) && (cfg_a || cba_a);
    wire cfg_w = acc && reg_wr_in && cfg_a && cap_present_in;
    wire cba_w = acc && reg_wr_in && cba_a && cap_present_in;
    wire ok_ld = ce_in && instr_in && load_in && cap_present_in &&
                 ext_feature_en_in && protected_mode_in;
    logic [63:0] wd_q; // Last written data, for field checks.
    always @(posedge clk_in) if (reg_wr_in && ce_in) wd_q <= reg_wdata_in;
    a_cap_gate: assert property (acc && !cap_present_in |=>
        gp_fault_out && !reg_ack_out) else $error("no gate on access");
    a_cfg_bad: assert property (cfg_w && reg_wdata_in[0] |=>
        gp_fault_out) else $error("bad config bit taken");
    a_cfg_ident: assert property (cfg_w ##1 reg_ack_out |->
        ##[0:1] core_id_out == wd_q[39:32] && vector_out == wd_q[47:40])
        else $error("core id or vector wrong");
    a_cfg_modes: assert property (cfg_w ##1 reg_ack_out |->
        ##[0:1] continuous_out == wd_q[29] &&
        int_allow_out == (wd_q[31] & pruned_flags_out[31]))
        else $error("mode bits wrong");
    a_cba_nonzero: assert property (cba_w && reg_wdata_in != 0 |=>
        gp_fault_out && !reg_ack_out) else $error("address write taken");
    a_cba_zero: assert property (cba_w && reg_wdata_in == 0 |=>
        !enabled_out) else $error("zero write left enabled");
    a_ud_fault: assert property (ce_in && instr_in &&
        (!cap_present_in || !ext_feature_en_in ||
        (load_in && !protected_mode_in)) |=> ud_fault_out)
        else $error("missing invalid opcode");
    a_zero_load: assert property (ok_ld && load_addr_in == 0 &&
        !enabled_out |=> load_done_out && !enabled_out && !check_req_out)
        else $error("zero load wrong");
    a_load_check: assert property (ok_ld && load_addr_in != 0 &&
        !enabled_out |=> check_req_out && !load_done_out)
        else $error("no validation step");
    a_fail_off: assert property (ce_in && check_fail_in |=>
        !enabled_out) else $error("enabled after failed check");
    a_xfe_gate: assert property (!ext_feature_en_in |=>
        !enabled_out) else $error("enabled without bit 62");
    c_load: cover property (load_done_out && enabled_out);
    c_gp: cover property (gp_fault_out);
    c_ud: cover property (ud_fault_out);
endmodule
`default_nettype wire

// ### testbench/lpc_profiler_ctrl_tb_top.sv
// Self-checking bench of the profiler control registers and load flow.
// Assumes the core answers memory steps; the bench plays that core.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_regs.vh"
module lpc_profiler_ctrl_tb_top;
    logic clk_in = 0, rst_in = 1, ce_in = 1, cap_present_in = 0;
    logic ext_feature_en_in = 1, protected_mode_in = 1;
    logic timestamp_avail_in = 1, instr_in = 0, load_in = 0;
    logic reg_rd_in = 0, reg_wr_in = 0, flush_done_in = 0, flush_pf_in = 0;
    logic check_done_in = 0, check_fail_in = 0, check_pf_in = 0;
    logic [31:0] supported_feat_in = 32'hE0000076, reg_addr_in = 0;
    logic [31:0] block_flags_in = 32'h8000007E, lf = 32'h65B7, pfl = 0;
    logic [63:0] data_seg_base_in = 64'h1000, reg_wdata_in = 0, rd, cfg;
    logic [63:0] load_addr_in = 0, ring_addr_in = 64'h8000;
    logic [191:0] intervals_in = {160'h0, 32'h3, 32'h0};
    logic [191:0] counters_in = {160'h64, 32'h0, 32'h64};
    logic [5:0] event_hit_in = 0;
    logic ak, gp;
    wire [63:0] reg_rdata_out, ring_linear_out;
    wire [31:0] pruned_flags_out;
    wire [191:0] interval_out;
    wire [7:0] core_id_out, vector_out;
    wire [5:0] record_req_out;
    wire reg_ack_out, gp_fault_out, ud_fault_out, load_done_out, flags_wb_out;
    wire flush_req_out, check_req_out, enabled_out, continuous_out;
    wire store_tsc_out, int_allow_out;
    int errors = 0, n_checks = 0, cyc = 0;
    localparam [31:0] CF = `LPC_ADDR_FEATURE_CONFIG;
    localparam [31:0] CB = `LPC_ADDR_CONTROL_BLOCK;
    lpc_profiler_ctrl uut (.*);
    always #2.5 clk_in = ~clk_in;
    // Cuts a hung run short.
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            errors++;
            finish_test;
        end
    end
    function automatic logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task chk(input string nm, input logic [63:0] s, e);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask
    // One register access; the answer is sampled mid-cycle after it.
    task rop(input logic w, input logic [31:0] a, input logic [63:0] d);
        @(posedge clk_in);
        {reg_rd_in, reg_wr_in, reg_addr_in, reg_wdata_in} <= {!w, w, a, d};
        @(posedge clk_in) {reg_rd_in, reg_wr_in} <= 2'b00;
        @(negedge clk_in) {ak, gp, rd} = {reg_ack_out, gp_fault_out,
            reg_rdata_out};
    endtask
    task ld(input logic [63:0] a);
        @(posedge clk_in) {instr_in, load_in, load_addr_in} <= {2'b11, a};
        @(posedge clk_in) {instr_in, load_in} <= 2'b00;
        @(negedge clk_in);
    endtask
    // Core answer pulse: 0 flush done, 1 flush fault, 2 check done, 3 fail.
    task ans(input int k);
        @(posedge clk_in) case (k)
            0: flush_done_in <= 1;
            1: flush_pf_in <= 1;
            2: check_done_in <= 1;
            default: check_fail_in <= 1;
        endcase
        @(posedge clk_in) {flush_done_in, flush_pf_in, check_done_in,
            check_fail_in} <= 4'h0;
        @(negedge clk_in);
    endtask
    task finish_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_in);
        rst_in <= 0;
        rop(0, CF, 0); chk("nocap gp", gp, 1);
        cap_present_in <= 1;
        rop(0, CF, 0); chk("cfg reset", rd, 0);
        rop(0, CB, 0); chk("cba ack", ak, 1);
        chk("cba read", rd, 0);
        rop(0, 32'hC0000107, 0); chk("unmapped", {ak, gp}, 0);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            lf = nx(lf);
            cfg = (i == 0) ? 64'hFFFFE0000076 :
                {16'h0, lf[15:0], lf & 32'hE0000076};
            rop(1, CF, cfg); rop(0, CF, 0); chk("cfg rd", rd, cfg);
            chk("core id", core_id_out, cfg[39:32]);
            chk("vector", vector_out, cfg[47:40]);
            chk("continuous_mode_enable", continuous_out, cfg[29]);
            chk("tsc", store_tsc_out, cfg[30] & timestamp_avail_in);
            chk("int", int_allow_out, cfg[31] & pfl[31]);
            timestamp_avail_in <= lf[7];
        end
        foreach (supported_feat_in[i]) if (i == 0 || i == 3 || i == 20) begin
            rop(1, CF, cfg | (64'h1 << i)); chk("bad cfg gp", gp, 1);
            rop(0, CF, 0); chk("cfg kept", rd, cfg);
        end
        rop(1, CF, 64'h5A00E0000076); cfg = 64'h5A00E0000076;
        chk("cfg wr", {ak, gp}, 2);
        rop(1, CB, 64'h40); chk("cba gp", {ak, gp}, 1);
        ext_feature_en_in <= 0; ld(64'h100); chk("ud xfe", ud_fault_out, 1);
        {ext_feature_en_in, protected_mode_in} <= 2'b10;
        ld(64'h100); chk("ud prot", ud_fault_out, 1);
        protected_mode_in <= 1;
        ld(0); chk("zero ld", {load_done_out, enabled_out}, 2);
        $display("test faults done");
        ld(64'h200); chk("check req", check_req_out, 1);
        ans(2); chk("en", {enabled_out, load_done_out, flags_wb_out}, 7);
        pfl = block_flags_in & cfg[31:0] & supported_feat_in & 32'h8000007E;
        chk("pruned", pruned_flags_out, pfl);
        @(negedge clk_in) chk("int ld", int_allow_out, cfg[31]);
        chk("ring lin", ring_linear_out, 64'h9000);
        chk("intv", interval_out[63:0], {32'hF, 32'h0});
        @(posedge clk_in) event_hit_in <= 6'b000110;
        @(posedge clk_in) event_hit_in <= 0;
        @(negedge clk_in) chk("record", record_req_out, 6'b000010);
        data_seg_base_in <= 64'h7000;
        rop(0, CB, 0); chk("cba lin", rd, 64'h1200);
        ld(64'h300); chk("flush req", flush_req_out, 1);
        ans(1); rop(0, CB, 0); chk("pf kept", enabled_out, 1);
        chk("pf addr", rd, 64'h1200);
        ld(0); ans(0); chk("zero en", {load_done_out, enabled_out}, 2);
        ld(64'h200); ans(3); chk("fail off", enabled_out, 0);
        ld(64'h200); ans(2); rop(1, CB, 0);
        chk("cba zero", {ak, enabled_out}, 2);
        ld(64'h200); ans(2); ext_feature_en_in <= 0;
        @(negedge clk_in) @(negedge clk_in) chk("xfe off", enabled_out, 0);
        $display("test load done");
        finish_test;
    end
endmodule
bind lpc_profiler_ctrl lpc_ctrl_sva chk_i (.*);
`default_nettype wire
